// ---- src/wiper_pkg.sv ----
// Constants shared by the serial wiper control logic
// Notes on behaviour
// RQ1: Code zero puts wiper at B end
// RQ2: Command 0xB address 0 loads wiper
// RQ3: Command 0x2 stores wiper, 25 ms
// RQ4: Wiper field is ten bits wide
// RQ5: Output shifts previous frame's word
// RQ6: Power-on loads wiper from store zero
// RQ7: Commands 0x1, 0x8 reload wiper from store
// RQ8: Preset low forces midscale, rise reloads
// RQ9: Step by one, shift doubles or halves
// RQ10: Bare chip-select strobe repeats last command
// RQ11: Write-protect blocks all but reloads
// RQ12: Host sends nop before releasing protect
// RQ13: Serial output released while deselected
// RQ14: Frames are 24 bits, MSB first
// RQ15: Execute only when chip select rises
// RQ16: Accept multiples of 24 bits only
// RQ17: Count not multiple of four discards
// RQ18: Works in modes 0,0 and 1,1
// RQ19: Codes 10, 9 read back; others chain
// RQ20: Host shifts 48 bits for two devices
// RQ21: Command, address, data fields select operation
// RQ22: Input shift register locked during store
// RQ23: Four command, four address, sixteen data
// RQ24: Readback appears in the following frame
// RQ25: Ready marks completion of slow commands
// RQ26: Step and shift saturate at limits
// RQ27: Strobe repeat ignored during store
package wiper_pkg;
   localparam int FRAME_BITS = 24;
   localparam int WIPER_BITS = 10;
   localparam int DATA_BITS = 16;
   localparam int CMD_MSB = 23;
   localparam int CMD_LSB = 20;
   localparam int ADDR_MSB = 19;
   localparam int ADDR_LSB = 16;
   localparam int STORE_WORDS = 16;
   localparam logic [9:0] WIPER_MIDSCALE = 10'h200;
   localparam logic [9:0] WIPER_FULL = 10'h3ff;
   localparam logic [15:0] STORE_RESET = 16'h0200;
   localparam logic [15:0] USER_RESET = 16'h0000;
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_RESTORE = 4'h1;
   localparam logic [3:0] CMD_STORE_WIPER = 4'h2;
   localparam logic [3:0] CMD_STORE_USER = 4'h3;
   localparam logic [3:0] CMD_DEC_6DB_A = 4'h4;
   localparam logic [3:0] CMD_DEC_6DB_B = 4'h5;
   localparam logic [3:0] CMD_DEC_STEP_A = 4'h6;
   localparam logic [3:0] CMD_DEC_STEP_B = 4'h7;
   localparam logic [3:0] CMD_RESET_LOAD = 4'h8;
   localparam logic [3:0] CMD_READ_STORE = 4'h9;
   localparam logic [3:0] CMD_READ_WIPER = 4'ha;
   localparam logic [3:0] CMD_WRITE_WIPER = 4'hb;
   localparam logic [3:0] CMD_INC_6DB_A = 4'hc;
   localparam logic [3:0] CMD_INC_6DB_B = 4'hd;
   localparam logic [3:0] CMD_INC_STEP_A = 4'he;
   localparam logic [3:0] CMD_INC_STEP_B = 4'hf;
   localparam int CLK_HZ = 50000000;
   localparam int STORE_TIME_MS = 25;
   localparam int STORE_CYCLES = STORE_TIME_MS * (CLK_HZ / 1000);
   localparam int BIT_CNT_BITS = 16;
endpackage

// ---- src/spi_frame_shifter.sv ----
// Serial shifter: synchronises pins, counts bits, flags frame ends
`timescale 1ns/10ps
`default_nettype none
module spi_frame_shifter (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic sdi_pin,
   input wire logic lock,
   input wire logic [23:0] load_word,
   input wire logic load_en,
   output logic [23:0] shift_word,
   output logic [15:0] bit_count,
   output logic cs_low,
   output logic frame_end,
   output logic sdo_bit
);
   // ==========================================
   // Pin synchronisers
   logic [1:0] sclk_sync;
   logic [1:0] cs_sync;
   logic [1:0] sdi_sync;
   logic sclk_prev;
   logic cs_prev;
   logic sclk_rise;
   logic sclk_fall;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclk_sync <= 2'h0;
         cs_sync <= 2'h3;
         sdi_sync <= 2'h0;
         sclk_prev <= 1'b0;
         cs_prev <= 1'b1;
      end else if (clk_en) begin
         sclk_sync <= {sclk_sync[0], sclk_pin};
         cs_sync <= {cs_sync[0], cs_n_pin};
         sdi_sync <= {sdi_sync[0], sdi_pin};
         sclk_prev <= sclk_sync[1];
         cs_prev <= cs_sync[1];
      end
   end

   // Edges looked at only on the second stage
   assign sclk_rise = clk_en && sclk_sync[1] && !sclk_prev;
   assign sclk_fall = clk_en && !sclk_sync[1] && sclk_prev;
   assign cs_low = !cs_sync[1];
   assign frame_end = clk_en && cs_sync[1] && !cs_prev;

   // ==========================================
   // Shift register and bit counter
   // Sample on rise, drive on fall: fits modes 0,0 and 1,1
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shift_word <= 24'h000000;
         bit_count <= 16'h0000;
      end else if (load_en) begin
         shift_word <= load_word;
         bit_count <= 16'h0000;
      end else if (clk_en && !lock && cs_low && sclk_rise) begin
         shift_word <= {shift_word[22:0], sdi_sync[1]}; // RQ14 RQ18 RQ22
         bit_count <= bit_count + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sdo_bit <= 1'b1;
      end else if (clk_en) begin
         if (!cs_low) begin
            sdo_bit <= 1'b1;
         end else if (sclk_fall || (cs_prev && cs_low)) begin
            sdo_bit <= shift_word[23]; // RQ5
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/spi_wiper_scratchpad_control.sv ----
// Command decode, wiper scratchpad and nonvolatile store control
`timescale 1ns/10ps
`default_nettype none
module spi_wiper_scratchpad_control (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic sclk_pin,
   input wire logic cs_n_pin,
   input wire logic sdi_pin,
   input wire logic write_protect_n_pin,
   input wire logic preset_reload_pin,
   output logic sdo_o,
   output logic sdo_oe,
   output logic ready_o,
   output logic ready_oe,
   output logic [9:0] wiper_scratchpad,
   output logic store_busy
);
   typedef enum logic [1:0] {
      ST_POWERUP = 2'b00,
      ST_IDLE = 2'b01,
      ST_STORE = 2'b10
   } state_e;

   state_e state;
   logic [15:0] nonvolatile_store [0:15];
   logic [23:0] shift_word;
   logic [15:0] bit_count;
   logic cs_low;
   logic frame_end;
   logic sdo_bit;
   logic load_en;
   logic [23:0] load_word;
   logic [1:0] wp_sync;
   logic [1:0] pr_sync;
   logic pr_prev;
   logic pr_rise;
   logic [31:0] store_count;
   logic [3:0] last_cmd;
   logic [3:0] last_addr;
   logic [15:0] last_data;
   logic [3:0] cmd;
   logic [3:0] addr;
   logic [15:0] data;
   logic execute;
   logic bare_strobe;
   logic count_ok;
   logic wp_active;
   logic ready;
   logic store_start;
   logic storing;
   logic powering_up;
   logic preset_held;

   spi_frame_shifter shifter (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .sclk_pin(sclk_pin),
      .cs_n_pin(cs_n_pin),
      .sdi_pin(sdi_pin),
      .lock(state == ST_STORE),
      .load_word(load_word),
      .load_en(load_en),
      .shift_word(shift_word),
      .bit_count(bit_count),
      .cs_low(cs_low),
      .frame_end(frame_end),
      .sdo_bit(sdo_bit)
   );

   // ==========================================
   // Control pin synchronisers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wp_sync <= 2'h3;
         pr_sync <= 2'h3;
         pr_prev <= 1'b1;
      end else if (clk_en) begin
         wp_sync <= {wp_sync[0], write_protect_n_pin};
         pr_sync <= {pr_sync[0], preset_reload_pin};
         pr_prev <= pr_sync[1];
      end
   end

   assign pr_rise = clk_en && pr_sync[1] && !pr_prev;
   assign wp_active = !wp_sync[1];

   // ==========================================
   // Frame decode
   assign count_ok = (bit_count[1:0] == 2'h0) &&
      ((bit_count % 16'h0018) == 16'h0000); // RQ16 RQ17
   assign bare_strobe = (bit_count == 16'h0000); // RQ10
   // A strobe during power-up or a store runs nothing
   assign execute = frame_end && (state == ST_IDLE) &&
      (count_ok || bare_strobe); // RQ15 RQ27
   assign cmd = bare_strobe ? last_cmd :
      shift_word[wiper_pkg::CMD_MSB:wiper_pkg::CMD_LSB]; // RQ21 RQ23
   assign addr = bare_strobe ? last_addr :
      shift_word[wiper_pkg::ADDR_MSB:wiper_pkg::ADDR_LSB];
   assign data = bare_strobe ? last_data :
      shift_word[wiper_pkg::DATA_BITS-1:0];
   // Ready drops on the very edge that enters the store
   assign store_start = execute && !wp_active &&
      (cmd == wiper_pkg::CMD_STORE_WIPER ||
       cmd == wiper_pkg::CMD_STORE_USER); // RQ3 RQ11

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last_cmd <= wiper_pkg::CMD_NOP;
         last_addr <= 4'h0;
         last_data <= 16'h0000;
      end else if (execute && !bare_strobe) begin
         last_cmd <= cmd;
         last_addr <= addr;
         last_data <= data;
      end
   end

   // ==========================================
   // Readback: loaded for the following frame
   always_comb begin
      load_en = 1'b0;
      load_word = shift_word;
      if (frame_end && !count_ok && !bare_strobe) begin
         load_en = 1'b1; // RQ17
      end else if (execute && cmd == wiper_pkg::CMD_READ_WIPER) begin
         load_en = 1'b1;
         load_word = {cmd, addr, 6'h00, wiper_scratchpad}; // RQ19 RQ24
      end else if (execute && cmd == wiper_pkg::CMD_READ_STORE) begin
         load_en = 1'b1;
         load_word = {cmd, addr, nonvolatile_store[addr]}; // RQ19 RQ24
      end else if (execute) begin
         load_en = 1'b1;
      end
   end

   // ==========================================
   // Sequencer: power-on load and store timing
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_POWERUP;
         store_count <= 32'h00000000;
      end else if (clk_en) begin
         case (state)
            ST_POWERUP: begin
               state <= ST_IDLE;
            end
            ST_IDLE: begin
               if (store_start) begin
                  state <= ST_STORE;
                  store_count <= 32'h00000000;
               end
            end
            ST_STORE: begin
               if (store_count == 32'(wiper_pkg::STORE_CYCLES - 1)) begin
                  state <= ST_IDLE; // RQ3 RQ22
               end else begin
                  store_count <= store_count + 32'h00000001;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // Nonvolatile store array
   // Stands in for cells; array resets to factory content
   genvar gi;
   generate
      for (gi = 0; gi < wiper_pkg::STORE_WORDS; gi++) begin : g_store
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               nonvolatile_store[gi] <= (gi == 0) ?
                  wiper_pkg::STORE_RESET : wiper_pkg::USER_RESET;
            end else if (clk_en && execute && !wp_active) begin
               if (gi == 0 && cmd == wiper_pkg::CMD_STORE_WIPER) begin
                  nonvolatile_store[gi] <= {6'h00, wiper_scratchpad}; // RQ3
               end else if (gi != 0 && addr == 4'(gi) &&
                  cmd == wiper_pkg::CMD_STORE_USER) begin
                  nonvolatile_store[gi] <= data;
               end
            end
         end
      end
   endgenerate

   // ==========================================
   // Busy sources for the ready pin
   assign powering_up = (state == ST_POWERUP);
   assign storing = (state == ST_STORE);
   assign preset_held = !pr_sync[1];

   // ==========================================
   // Wiper adjustment helpers
   // Limits checked once so every command saturates alike
   logic wiper_at_zero;
   logic wiper_at_full;
   logic [9:0] wiper_up;
   logic [9:0] wiper_down;
   logic [9:0] wiper_double;
   logic [9:0] wiper_half;
   logic wiper_change_ok;

   assign wiper_at_zero = (wiper_scratchpad == 10'h000);
   assign wiper_at_full = (wiper_scratchpad == wiper_pkg::WIPER_FULL);
   assign wiper_up = wiper_at_full ? wiper_scratchpad :
      wiper_scratchpad + 10'h001; // RQ9 RQ26
   assign wiper_down = wiper_at_zero ? wiper_scratchpad :
      wiper_scratchpad - 10'h001; // RQ9 RQ26
   // Top bit set: doubling would overflow, so clamp
   assign wiper_double = wiper_scratchpad[9] ? wiper_pkg::WIPER_FULL :
      {wiper_scratchpad[8:0], 1'b0}; // RQ9 RQ26
   assign wiper_half = {1'b0, wiper_scratchpad[9:1]}; // RQ9
   // Reloads bypass this, so they still work under protect
   assign wiper_change_ok = !wp_active; // RQ11

   // ==========================================
   // Wiper scratchpad
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wiper_scratchpad <= wiper_pkg::WIPER_MIDSCALE;
      end else if (clk_en) begin
         if (preset_held) begin
            wiper_scratchpad <= wiper_pkg::WIPER_MIDSCALE; // RQ8
         end else if (pr_rise || powering_up) begin
            wiper_scratchpad <= nonvolatile_store[0][9:0]; // RQ6 RQ8
         end else if (execute) begin
            case (cmd)
               wiper_pkg::CMD_RESTORE, wiper_pkg::CMD_RESET_LOAD: begin
                  wiper_scratchpad <= nonvolatile_store[0][9:0]; // RQ7
               end
               wiper_pkg::CMD_WRITE_WIPER: begin
                  if (wiper_change_ok && addr == 4'h0) begin
                     wiper_scratchpad <= data[9:0]; // RQ2 RQ4 RQ11
                  end
               end
               wiper_pkg::CMD_DEC_STEP_A, wiper_pkg::CMD_DEC_STEP_B: begin
                  if (wiper_change_ok) begin
                     wiper_scratchpad <= wiper_down; // RQ9 RQ26
                  end
               end
               wiper_pkg::CMD_INC_STEP_A, wiper_pkg::CMD_INC_STEP_B: begin
                  if (wiper_change_ok) begin
                     wiper_scratchpad <= wiper_up; // RQ9 RQ26
                  end
               end
               wiper_pkg::CMD_DEC_6DB_A, wiper_pkg::CMD_DEC_6DB_B: begin
                  if (wiper_change_ok) begin
                     wiper_scratchpad <= wiper_half; // RQ9
                  end
               end
               wiper_pkg::CMD_INC_6DB_A, wiper_pkg::CMD_INC_6DB_B: begin
                  if (wiper_change_ok) begin
                     wiper_scratchpad <= wiper_double; // RQ9 RQ26
                  end
               end
               default: begin
                  wiper_scratchpad <= wiper_scratchpad;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Ready: low while busy, high after completion
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ready <= 1'b0;
      end else if (clk_en) begin
         if (powering_up || storing || store_start || preset_held) begin
            ready <= 1'b0; // RQ25
         end else begin
            ready <= 1'b1; // RQ25
         end
      end
   end

   // Open-drain pins: only ever pull low
   assign sdo_o = 1'b0;
   assign sdo_oe = cs_low && !sdo_bit; // RQ13
   assign ready_o = 1'b0;
   assign ready_oe = !ready;
   assign store_busy = storing;
   // Code zero is B end; analog ladder outside this block
   // RQ1
endmodule
`default_nettype wire

// ---- test/wiper_checks_assertions.sv ----
// Checker for the serial wiper control outputs
`timescale 1ns/10ps
`default_nettype none
module wiper_checks (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic cs_n_pin,
   input wire logic write_protect_n_pin,
   input wire logic preset_reload_pin,
   input wire logic sdo_oe,
   input wire logic ready_oe,
   input wire logic [9:0] wiper_scratchpad,
   input wire logic store_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========
   // Sequences
   // Eight quiet cycles cover sync plus decode latency
   sequence s_quiet;
      (cs_n_pin && preset_reload_pin) [*8];
   endsequence
   sequence s_preset_low;
      (!preset_reload_pin) [*4];
   endsequence
   // ==========
   // Properties
   property p_boot_mid;
      $fell(sys_rst) |-> ##[0:2]
         wiper_scratchpad == wiper_pkg::WIPER_MIDSCALE;
   endproperty
   property p_ready_boot;
      $fell(sys_rst) && preset_reload_pin |-> ##[1:4] !ready_oe;
   endproperty
   property p_sdo_idle;
      cs_n_pin [*4] |-> !sdo_oe;
   endproperty
   property p_preset_mid;
      s_preset_low |-> wiper_scratchpad == wiper_pkg::WIPER_MIDSCALE;
   endproperty
   property p_ready_preset;
      s_preset_low |-> ready_oe;
   endproperty
   property p_ready_store;
      store_busy |-> ready_oe;
   endproperty
   property p_store_hold;
      $rose(store_busy) |=> store_busy [*8];
   endproperty
   property p_wp_store;
      (!write_protect_n_pin) [*8] |-> !$rose(store_busy);
   endproperty
   property p_exec_quiet;
      s_quiet |-> $stable(wiper_scratchpad);
   endproperty
   a_boot_mid: assert property (p_boot_mid)
      else $error("wiper not reloaded after reset");
   a_ready_boot: assert property (p_ready_boot)
      else $error("ready not released after reset");
   a_sdo_idle: assert property (p_sdo_idle)
      else $error("data output pulled while deselected");
   a_preset_mid: assert property (p_preset_mid)
      else $error("wiper not midscale while preset low");
   a_ready_preset: assert property (p_ready_preset)
      else $error("ready not low while preset low");
   a_ready_store: assert property (p_ready_store)
      else $error("ready not low during store");
   a_store_hold: assert property (p_store_hold)
      else $error("store ended too early");
   a_wp_store: assert property (p_wp_store)
      else $error("store started under write protect");
   a_exec_quiet: assert property (p_exec_quiet)
      else $error("wiper moved without a frame end");
endmodule
bind spi_wiper_scratchpad_control wiper_checks chk (
   .clk(clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin),
   .write_protect_n_pin(write_protect_n_pin),
   .preset_reload_pin(preset_reload_pin), .sdo_oe(sdo_oe),
   .ready_oe(ready_oe), .wiper_scratchpad(wiper_scratchpad),
   .store_busy(store_busy)
);
`default_nettype wire

// ---- test/host_master.sv ----
// Host controller model driving frames onto the serial pins
`timescale 1ns/10ps
`default_nettype none
module host_master (
   input wire logic sdo_line,
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // ==========
   // Frame of n bits, idle level cpol
   task automatic xfer(input logic [47:0] w, input int n,
      input logic cpol, output logic [47:0] r);
      r = '0;
      #7;
      sclk = cpol;
      #40;
      cs_n = 1'b0;
      #100;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b0;
         sdi = w[i];
         #80;
         sclk = 1'b1;
         r[i] = sdo_line;
         #80;
      end
      sclk = cpol;
      // Released line must not keep showing the last bit
      sdi = ~sdi;
      #80;
      cs_n = 1'b1;
      #200;
   endtask
   // Chip-select pulse with no clock
   task automatic strobe();
      cs_n = 1'b0;
      #100;
      cs_n = 1'b1;
      #200;
   endtask
endmodule
`default_nettype wire

// ---- test/spi_wiper_scratchpad_control_bench.sv ----
// Self-checking bench for the serial wiper control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; \
   if ((got) !== (exp)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
   end end
module spi_wiper_scratchpad_control_bench;
   logic clk, sys_rst, wp_n, preset_n, en;
   wire sclk, cs_n, sdi, sdo_o, sdo_oe, ready_o, ready_oe, busy;
   wire sdo_line;
   wire [9:0] wiper;
   logic [47:0] rd;
   int error_cnt = 0;
   int total_checks = 0;
   logic [15:0] step_tab [16] = '{16'he000, 16'hf000, 16'h6000,
      16'h7000, 16'hc000, 16'hd000, 16'h4000, 16'h5000, 16'hb3fe,
      16'he000, 16'hf000, 16'hc000, 16'hb001, 16'h6000, 16'h7000,
      16'h4000};
   logic [9:0] step_exp [16] = '{10'h101, 10'h102, 10'h101, 10'h100,
      10'h200, 10'h3ff, 10'h1ff, 10'h0ff, 10'h3fe, 10'h3ff, 10'h3ff,
      10'h3ff, 10'h001, 10'h000, 10'h000, 10'h000};
   int lens [3] = '{20, 23, 25};
   // Open-drain line with pull-up
   assign sdo_line = sdo_oe ? sdo_o : 1'b1;
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   spi_wiper_scratchpad_control dut (.clk(clk), .sys_rst(sys_rst),
      .clk_en(en), .sclk_pin(sclk), .cs_n_pin(cs_n), .sdi_pin(sdi),
      .write_protect_n_pin(wp_n), .preset_reload_pin(preset_n),
      .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ready_o(ready_o),
      .ready_oe(ready_oe), .wiper_scratchpad(wiper), .store_busy(busy));
   host_master host (.sdo_line(sdo_line), .sclk(sclk), .cs_n(cs_n),
      .sdi(sdi));
   // ==========
   // Tasks
   task automatic end_sim();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic frame(input logic [23:0] w, input logic [9:0] exp);
      @(negedge clk);
      host.xfer({24'h0, w}, 24, 1'b0, rd);
      `CHK(wiper, exp)
   endtask
   // Hang guard: whole run is far below this
   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
   // ==========
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      en = 1'b1;
      wp_n = 1'b1;
      preset_n = 1'b1;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      `CHK(wiper, 10'h200)
      `CHK(sdo_oe, 1'b0)
      frame(24'hb00100, 10'h100);
      frame(24'ha00000, 10'h100);
      `CHK(rd[23:0], 24'hb00100)
      frame(24'h900000, 10'h100);
      `CHK(rd[23:0], 24'ha00100)
      frame(24'h000000, 10'h100);
      `CHK(rd[23:0], 24'h900200)
      foreach (step_tab[i]) begin
         frame({step_tab[i][15:12], 8'h00, step_tab[i][11:0]},
            step_exp[i]);
      end
      frame(24'hb00005, 10'h005);
      frame(24'he00000, 10'h006);
      host.strobe();
      `CHK(wiper, 10'h007)
      foreach (lens[i]) begin
         host.xfer(48'hb00055, lens[i], 1'b0, rd);
         `CHK(wiper, 10'h007)
      end
      host.xfer(48'hb00011b00022, 48, 1'b0, rd);
      `CHK(wiper, 10'h022)
      host.xfer(48'hb00033, 24, 1'b1, rd);
      `CHK(wiper, 10'h033)
      frame(24'h100000, 10'h200);
      frame(24'hb00044, 10'h044);
      frame(24'h800000, 10'h200);
      frame(24'hb00066, 10'h066);
      @(negedge clk);
      wp_n = 1'b0;
      frame(24'hb00123, 10'h066);
      frame(24'he00000, 10'h066);
      frame(24'h310002, 10'h066);
      `CHK(busy, 1'b0)
      frame(24'h100000, 10'h200);
      frame(24'h000000, 10'h200);
      @(negedge clk);
      wp_n = 1'b1;
      frame(24'hb00077, 10'h077);
      // Frozen block must miss a whole frame
      @(negedge clk);
      en = 1'b0;
      frame(24'hb00155, 10'h077);
      @(negedge clk);
      en = 1'b1;
      @(negedge clk);
      preset_n = 1'b0;
      repeat (6) @(negedge clk);
      `CHK(wiper, 10'h200)
      `CHK(ready_oe, 1'b1)
      preset_n = 1'b1;
      repeat (6) @(negedge clk);
      `CHK(wiper, 10'h200)
      `CHK(ready_oe, 1'b0)
      frame(24'hb00088, 10'h088);
      frame(24'h200000, 10'h088);
      `CHK(busy, 1'b1)
      `CHK(ready_oe, 1'b1)
      frame(24'hb00099, 10'h088);
      host.strobe();
      `CHK(wiper, 10'h088)
      // Reload must show the stored word, not midscale
      @(negedge clk);
      preset_n = 1'b0;
      repeat (6) @(negedge clk);
      `CHK(wiper, 10'h200)
      preset_n = 1'b1;
      repeat (6) @(negedge clk);
      `CHK(wiper, 10'h088)
      `CHK(busy, 1'b1)
      end_sim();
   end
endmodule
`default_nettype wire
